// File: rtl/sfew_core.sv
// What this block does
// - Opcode picks 4K, 32K or 64K erase
// - Erased region reads all ones
// - Three address bytes, extras ignored, start on release
// - Low address bits ignored per erase size
// - Short address or partial byte aborts erase
// - Protected target skips erase, back to idle
// - Aborted block erase clears the latch
// - Busy reported while erase runs
// - Latch cleared before erase completes
// - Failed byte verify sets error flag
// - 60h and C7h both erase whole array
// - Partial byte on array erase aborts
// - Any protected sector refuses array erase
// - Rejected array erase clears the latch
// - Modifying commands need latch already set
// - 06h sets latch on release
// - 04h clears latch on release
// - Partial opcode leaves latch unchanged
// - Erase runs on internal timing
`timescale 1ns/10ps
module sfew_core
	import sfew_pkg::*;
#(
	parameter int BLOCK_ERASE_CYC = BLOCK_ERASE_CYCLES,
	parameter int WHOLE_ARRAY_ERASE_CYC = WHOLE_ARRAY_ERASE_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic spi_cs_b_i,
	input wire logic spi_sck_i,
	input wire logic spi_mosi_i,
	input wire logic [sfew_pkg::SECTOR_CNT-1:0] sector_protect_i,
	input wire logic [sfew_pkg::SECTOR_CNT-1:0] sector_lockdown_i,
	input wire logic verify_fail_i,
	output logic write_enable_latch_o,
	output logic busy_o,
	output logic erase_program_error_flag_o,
	output logic erase_active_o,
	output logic [sfew_pkg::ADDR_W-1:0] erase_first_addr_o,
	output logic [sfew_pkg::ADDR_W-1:0] erase_last_addr_o,
	output logic erase_fill_ones_o
);
	import sfew_pkg::*;

	typedef enum {ST_OPCODE, ST_ADDR, ST_IGNORE} sfew_state_t;

	logic rst_meta, rst_sync;
	logic [1:0] cs_sync, sck_sync, mosi_sync;
	logic cs_b, cs_b_d, sck, sck_d, mosi;
	logic sck_rise, cs_fall, cs_rise;
	logic [2:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] opcode;
	logic [1:0] addr_cnt;
	logic [ADDR_W-1:0] addr;
	sfew_state_t state;
	logic byte_done;
	logic [7:0] next_byte;
	logic start;
	sfew_size_t start_size;
	logic [ADDR_W-1:0] start_base;
	logic eng_busy, eng_done, eng_fail;
	logic [ADDR_W-1:0] reg_base, reg_last;
	logic [SECTOR_CNT-1:0] guarded;
	logic is_block, is_array, target_guarded;
	logic [ADDR_W-1:0] masked_addr;
	sfew_size_t blk_size;

	// Reset release through two flops so all logic leaves reset together
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Pins cross into the reference clock; only stage two is read
	always_ff @(posedge ref_clk_i or negedge rst_sync) begin
		if (!rst_sync) begin
			cs_sync <= 2'b11;
			sck_sync <= 2'b00;
			mosi_sync <= 2'b00;
			cs_b_d <= 1'b1;
			sck_d <= 1'b0;
		end else begin
			cs_sync <= {cs_sync[0], spi_cs_b_i};
			sck_sync <= {sck_sync[0], spi_sck_i};
			mosi_sync <= {mosi_sync[0], spi_mosi_i};
			cs_b_d <= cs_b;
			sck_d <= sck;
		end
	end

	assign cs_b = cs_sync[1];
	assign sck = sck_sync[1];
	assign mosi = mosi_sync[1];
	assign sck_rise = sck && !sck_d && !cs_b;
	assign cs_fall = !cs_b && cs_b_d;
	assign cs_rise = cs_b && !cs_b_d;
	assign next_byte = {shift[6:0], mosi};
	assign byte_done = sck_rise && (bit_cnt == 3'h7);

	// Bit and byte framing; bit_cnt nonzero at release means off a byte boundary
	always_ff @(posedge ref_clk_i or negedge rst_sync) begin
		if (!rst_sync) begin
			bit_cnt <= 3'h0;
			shift <= 8'h00;
		end else if (cs_fall) begin
			bit_cnt <= 3'h0;
		end else if (sck_rise) begin
			bit_cnt <= bit_cnt + 3'h1;
			shift <= next_byte;
		end
	end

	// Command parser
	always_ff @(posedge ref_clk_i or negedge rst_sync) begin
		if (!rst_sync) begin
			state <= ST_OPCODE;
			opcode <= 8'h00;
			addr_cnt <= 2'h0;
			addr <= '0;
		end else if (cs_fall) begin
			state <= ST_OPCODE;
			opcode <= 8'h00;
			addr_cnt <= 2'h0;
		end else if (byte_done) begin
			unique case (state)
				ST_OPCODE: begin
					opcode <= next_byte;
					if (next_byte == OP_ERASE_4K || next_byte == OP_ERASE_32K || next_byte == OP_ERASE_64K) begin
						state <= ST_ADDR;
					end else begin
						state <= ST_IGNORE;
					end
				end
				ST_ADDR: begin
					addr <= {addr[ADDR_W-9:0], next_byte};
					addr_cnt <= addr_cnt + 2'h1;
					if (addr_cnt == 2'(ADDR_BYTES - 1)) begin
						state <= ST_IGNORE;
					end
				end
				ST_IGNORE: begin
					state <= ST_IGNORE;
				end
			endcase
		end
	end

	always_comb begin
		unique case (opcode)
			OP_ERASE_32K: blk_size = SFEW_SZ_32K;
			OP_ERASE_64K: blk_size = SFEW_SZ_64K;
			default: blk_size = SFEW_SZ_4K;
		endcase
	end

	always_comb begin
		unique case (blk_size)
			SFEW_SZ_32K: masked_addr = addr & ~ADDR_W'((1 << MASK_32K_BITS) - 1);
			SFEW_SZ_64K: masked_addr = addr & ~ADDR_W'((1 << MASK_64K_BITS) - 1);
			default: masked_addr = addr & ~ADDR_W'((1 << MASK_4K_BITS) - 1);
		endcase
	end

	assign guarded = sector_protect_i | sector_lockdown_i;
	assign target_guarded = guarded[addr[SECTOR_LSB +: SECTOR_W]];
	assign is_block = opcode == OP_ERASE_4K || opcode == OP_ERASE_32K || opcode == OP_ERASE_64K;
	assign is_array = opcode == OP_ARRAY_ERASE_A || opcode == OP_ARRAY_ERASE_B;

	// Decision at chip select release; a running erase makes every command a no-op
	always_ff @(posedge ref_clk_i or negedge rst_sync) begin
		if (!rst_sync) begin
			write_enable_latch_o <= 1'b0;
			start <= 1'b0;
			start_size <= SFEW_SZ_4K;
			start_base <= '0;
		end else begin
			start <= 1'b0;
			if (eng_busy) begin
				write_enable_latch_o <= 1'b0;
			end else if (cs_rise && state != ST_OPCODE) begin
				if (bit_cnt != 3'h0) begin
					if (is_block || is_array) begin
						write_enable_latch_o <= 1'b0;
					end
				end else if (is_block) begin
					if (state != ST_IGNORE || target_guarded) begin
						write_enable_latch_o <= 1'b0;
					end else if (write_enable_latch_o) begin
						start <= 1'b1;
						start_size <= blk_size;
						start_base <= masked_addr;
					end
				end else if (is_array) begin
					if (|guarded) begin
						write_enable_latch_o <= 1'b0;
					end else if (write_enable_latch_o) begin
						start <= 1'b1;
						start_size <= SFEW_SZ_ALL;
						start_base <= '0;
					end
				end else if (opcode == OP_WRITE_ENABLE) begin
					write_enable_latch_o <= 1'b1;
				end else if (opcode == OP_WRITE_DISABLE) begin
					write_enable_latch_o <= 1'b0;
				end
			end
		end
	end

	sfew_erase_engine #(
		.BLOCK_CYCLES(BLOCK_ERASE_CYC),
		.ARRAY_CYCLES(WHOLE_ARRAY_ERASE_CYC)
	) i_sfew_erase_engine (
		.clk_i(ref_clk_i),
		.rst_b_i(rst_sync),
		.start_i(start),
		.size_i(start_size),
		.base_i(start_base),
		.verify_fail_i(verify_fail_i),
		.busy_o(eng_busy),
		.done_o(eng_done),
		.fail_o(eng_fail),
		.region_base_o(reg_base),
		.region_last_o(reg_last)
	);

	// Status outputs registered; busy covers the start cycle too so polling never sees a gap
	always_ff @(posedge ref_clk_i or negedge rst_sync) begin
		if (!rst_sync) begin
			busy_o <= 1'b0;
			erase_program_error_flag_o <= 1'b0;
			erase_active_o <= 1'b0;
			erase_first_addr_o <= '0;
			erase_last_addr_o <= '0;
			erase_fill_ones_o <= 1'b0;
		end else begin
			busy_o <= start | eng_busy;
			erase_active_o <= eng_busy;
			erase_fill_ones_o <= eng_busy;
			erase_first_addr_o <= reg_base;
			erase_last_addr_o <= reg_last;
			if (start) begin
				erase_program_error_flag_o <= 1'b0;
			end else if (eng_done) begin
				erase_program_error_flag_o <= eng_fail;
			end
		end
	end
endmodule : sfew_core

// File: rtl/sfew_erase_engine.sv
// Self-timed erase engine with busy, done and verify fail; the core clears the latch from busy
`timescale 1ns/10ps
module sfew_erase_engine
	import sfew_pkg::*;
#(
	parameter int BLOCK_CYCLES = 5000000,
	parameter int ARRAY_CYCLES = 100000000
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic start_i,
	input wire sfew_pkg::sfew_size_t size_i,
	input wire logic [sfew_pkg::ADDR_W-1:0] base_i,
	input wire logic verify_fail_i,
	output logic busy_o,
	output logic done_o,
	output logic fail_o,
	output logic [sfew_pkg::ADDR_W-1:0] region_base_o,
	output logic [sfew_pkg::ADDR_W-1:0] region_last_o
);
	import sfew_pkg::*;

	logic [TIMER_W-1:0] timer;
	logic fail_seen;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			fail_o <= 1'b0;
			timer <= '0;
			fail_seen <= 1'b0;
			region_base_o <= '0;
			region_last_o <= '0;
		end else begin
			done_o <= 1'b0;
			if (start_i && !busy_o) begin
				busy_o <= 1'b1;
				fail_seen <= 1'b0;
				region_base_o <= base_i;
				unique case (size_i)
					SFEW_SZ_4K: region_last_o <= base_i | ADDR_W'((1 << MASK_4K_BITS) - 1);
					SFEW_SZ_32K: region_last_o <= base_i | ADDR_W'((1 << MASK_32K_BITS) - 1);
					SFEW_SZ_64K: region_last_o <= base_i | ADDR_W'((1 << MASK_64K_BITS) - 1);
					// Array ends at the top of the last sector, not at the top of the address space
					SFEW_SZ_ALL: region_last_o <= ADDR_W'((SECTOR_CNT << SECTOR_LSB) - 1);
				endcase
				timer <= (size_i == SFEW_SZ_ALL) ? TIMER_W'(ARRAY_CYCLES - 1) : TIMER_W'(BLOCK_CYCLES - 1);
			end else if (busy_o) begin
				if (verify_fail_i) begin
					fail_seen <= 1'b1;
				end
				if (timer == '0) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
					fail_o <= fail_seen | verify_fail_i;
				end else begin
					timer <= timer - 1'b1;
				end
			end
		end
	end
endmodule : sfew_erase_engine

// File: rtl/sfew_pkg.sv
// Constants for the serial flash erase and write enable latch block
package sfew_pkg;
	localparam logic [7:0] OP_ERASE_4K = 8'h20;
	localparam logic [7:0] OP_ERASE_32K = 8'h52;
	localparam logic [7:0] OP_ERASE_64K = 8'hD8;
	localparam logic [7:0] OP_ARRAY_ERASE_A = 8'h60;
	localparam logic [7:0] OP_ARRAY_ERASE_B = 8'hC7;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam int ADDR_W = 24;
	localparam int SECTOR_CNT = 16;
	localparam int SECTOR_LSB = 16;
	localparam int SECTOR_W = 4;
	localparam int MASK_4K_BITS = 12;
	localparam int MASK_32K_BITS = 15;
	localparam int MASK_64K_BITS = 16;
	localparam int ADDR_BYTES = 3;
	localparam int CLK_MHZ = 100;
	localparam int BLOCK_ERASE_TIME_US = 50000;
	localparam int WHOLE_ARRAY_ERASE_TIME_US = 1000000;
	localparam int BLOCK_ERASE_CYCLES = BLOCK_ERASE_TIME_US * CLK_MHZ;
	localparam int WHOLE_ARRAY_ERASE_CYCLES = WHOLE_ARRAY_ERASE_TIME_US * CLK_MHZ;
	localparam int TIMER_W = 32;
	typedef enum logic [1:0] {SFEW_SZ_4K, SFEW_SZ_32K, SFEW_SZ_64K, SFEW_SZ_ALL} sfew_size_t;
endpackage : sfew_pkg

// File: test/sfew_core_sva.sv
// Checker for the erase and latch block, bound to its top module
`timescale 1ns/10ps
module sfew_core_sva
	import sfew_pkg::*;
#(
	parameter int BLOCK_ERASE_CYC = 50,
	parameter int WHOLE_ARRAY_ERASE_CYC = 200
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic spi_cs_b_i,
	input wire logic write_enable_latch_o,
	input wire logic busy_o,
	input wire logic erase_program_error_flag_o,
	input wire logic erase_active_o,
	input wire logic [sfew_pkg::ADDR_W-1:0] erase_first_addr_o,
	input wire logic [sfew_pkg::ADDR_W-1:0] erase_last_addr_o,
	input wire logic erase_fill_ones_o
);
	logic [31:0] busy_cnt;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_cnt <= '0;
		end else if (busy_o) begin
			busy_cnt <= busy_cnt + 32'h1;
		end else begin
			busy_cnt <= '0;
		end
	end
	property p_latch_off(); busy_o && $past(busy_o) |-> !write_enable_latch_o; endproperty
	a_latch_off: assert property (p_latch_off) else $error("latch set during erase");
	property p_no_we_busy(); $rose(write_enable_latch_o) |-> !busy_o && !$past(busy_o); endproperty
	a_no_we_busy: assert property (p_no_we_busy) else $error("latch set while busy");
	property p_start_cs(); $rose(busy_o) |-> spi_cs_b_i && $past(spi_cs_b_i, 4); endproperty
	a_start_cs: assert property (p_start_cs) else $error("erase began without release");
	property p_latch_cs(); $changed(write_enable_latch_o) |-> $past(spi_cs_b_i, 3); endproperty
	a_latch_cs: assert property (p_latch_cs) else $error("latch moved inside a frame");
	property p_fill(); erase_fill_ones_o |-> busy_o; endproperty
	a_fill: assert property (p_fill) else $error("fill outside erase");
	property p_active(); erase_active_o |-> busy_o; endproperty
	a_active: assert property (p_active) else $error("array driven while idle");
	property p_err_set(); $rose(erase_program_error_flag_o) |-> busy_o || $past(busy_o); endproperty
	a_err_set: assert property (p_err_set) else $error("error flag set while idle");
	property p_err_clr(); $fell(erase_program_error_flag_o) |-> ##[0:3] busy_o; endproperty
	a_err_clr: assert property (p_err_clr) else $error("error flag dropped without erase");
	property p_busy_max(); busy_cnt <= WHOLE_ARRAY_ERASE_CYC + 2; endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy never ends");
	property p_busy_min(); $fell(busy_o) |-> $past(busy_cnt) >= BLOCK_ERASE_CYC; endproperty
	a_busy_min: assert property (p_busy_min) else $error("erase too short");
	property p_align(); busy_o && $past(busy_o) |-> erase_first_addr_o[11:0] == 12'h000
		&& erase_last_addr_o[11:0] == 12'hFFF; endproperty
	a_align: assert property (p_align) else $error("region not block aligned");
	c_erase: cover property ($rose(busy_o));
	c_latch_clr: cover property ($fell(write_enable_latch_o) && !busy_o);
	c_err: cover property ($rose(erase_program_error_flag_o));
endmodule : sfew_core_sva
bind sfew_core sfew_core_sva #(.BLOCK_ERASE_CYC(BLOCK_ERASE_CYC), .WHOLE_ARRAY_ERASE_CYC(WHOLE_ARRAY_ERASE_CYC))
	i_sfew_core_sva (.ref_clk_i, .rst_b_i, .spi_cs_b_i, .write_enable_latch_o, .busy_o, .erase_program_error_flag_o,
	.erase_active_o, .erase_first_addr_o, .erase_last_addr_o, .erase_fill_ones_o);

// File: test/sfew_core_tb_top.sv
// Self-checking bench for the erase and latch block
`timescale 1ns/10ps
module sfew_core_tb_top;
	import sfew_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic verify_fail_i = 1'b0;
	logic [SECTOR_CNT-1:0] prot = '0;
	logic [SECTOR_CNT-1:0] lock = '0;
	wire cs_b, sck, mosi, latch, busy, err;
	wire [ADDR_W-1:0] first, last;
	int miscompares = 0;
	int total_checks = 0;
	int seed = 32'hFAA0164F;
	logic [1:0] q_st[$];
	logic [48:0] q_rg[$];
	logic [48:0] rg;
	event chk_ev;
	always #5 ref_clk_i = ~ref_clk_i;
	sfew_core #(.BLOCK_ERASE_CYC(50), .WHOLE_ARRAY_ERASE_CYC(200)) i_sfew_core (.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i), .spi_cs_b_i(cs_b), .spi_sck_i(sck), .spi_mosi_i(mosi), .sector_protect_i(prot),
		.sector_lockdown_i(lock), .verify_fail_i(verify_fail_i), .write_enable_latch_o(latch), .busy_o(busy),
		.erase_program_error_flag_o(err), .erase_active_o(), .erase_first_addr_o(first),
		.erase_last_addr_o(last), .erase_fill_ones_o());
	sfew_spi_host i_sfew_spi_host (.clk_i(ref_clk_i), .spi_cs_b_o(cs_b), .spi_sck_o(sck), .spi_mosi_o(mosi));
	task automatic check(input logic [48:0] seen, input logic [48:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done;
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done
	task automatic cmd(input logic [39:0] b, input int n, input logic [1:0] st);
		i_sfew_spi_host.xfer(b, n);
		q_st.push_back(st);
		->chk_ev;
	endtask : cmd
	task automatic wait_idle;
		for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge ref_clk_i);
		#1;
	endtask : wait_idle
	initial forever begin
		@(chk_ev);
		check({latch, busy}, q_st.pop_front());
	end
	// An erase nobody asked for pops an empty queue and shows up as a mismatch
	initial forever begin
		@(posedge busy);
		repeat (2) @(negedge ref_clk_i);
		rg = q_rg.pop_front();
		check({first, last}, rg[47:0]);
		@(negedge busy);
		@(negedge ref_clk_i);
		check(err, rg[48]);
	end
	initial begin
		#400000;
		miscompares++;
		test_done;
	end
	initial begin
		logic [23:0] a;
		logic [23:0] m;
		logic [7:0] op;
		repeat (5) @(posedge ref_clk_i);
		#1 rst_b_i = 1'b1;
		repeat (5) @(posedge ref_clk_i);
		#1;
		cmd({OP_ERASE_4K, 32'h0}, 32, 2'b00);
		cmd({OP_WRITE_ENABLE, 32'h0}, 7, 2'b00);
		cmd({OP_WRITE_ENABLE, 32'hFF00_0000}, 16, 2'b10);
		cmd({OP_WRITE_DISABLE, 32'h0}, 9, 2'b10);
		cmd({OP_WRITE_DISABLE, 32'h0}, 8, 2'b00);
		for (int k = 0; k < 5; k++) begin
			op = k == 0 ? OP_ERASE_4K : k == 1 ? OP_ERASE_32K : k == 2 ? OP_ERASE_64K : k == 3 ?
				OP_ARRAY_ERASE_A : OP_ARRAY_ERASE_B;
			m = k == 0 ? 24'h000FFF : k == 1 ? 24'h007FFF : 24'h00FFFF;
			a = k > 2 ? 24'h000000 : 24'($random(seed)) & 24'h0FFFFF;
			m = k > 2 ? 24'((SECTOR_CNT << SECTOR_LSB) - 1) : m;
			prot = k > 2 ? '0 : SECTOR_CNT'($random(seed));
			lock = k > 2 ? '0 : SECTOR_CNT'($random(seed));
			prot[a[19:16]] = 1'b0;
			lock[a[19:16]] = 1'b0;
			verify_fail_i = 1'($random(seed));
			cmd({OP_WRITE_ENABLE, 32'h0}, 8, 2'b10);
			q_rg.push_back({verify_fail_i, a & ~m, a | m});
			cmd({op, a, 8'hA5}, k > 2 ? 16 : 40, 2'b01);
			wait_idle;
			cmd({OP_WRITE_ENABLE, 32'h0}, 8, 2'b10);
			cmd({op, a, 8'h00}, k > 2 ? 12 : 24, 2'b00);
			cmd({OP_WRITE_ENABLE, 32'h0}, 8, 2'b10);
			cmd({op, a, 8'h00}, k > 2 ? 9 : 33, 2'b00);
			// Block erase must hit its own sector; array erase is refused for any guarded sector
			if (k[0]) begin
				lock[k > 2 ? 4'(k) : a[19:16]] = 1'b1;
			end else begin
				prot[a[19:16]] = 1'b1;
			end
			cmd({OP_WRITE_ENABLE, 32'h0}, 8, 2'b10);
			cmd({op, a, 8'h00}, k > 2 ? 8 : 32, 2'b00);
		end
		test_done;
	end
endmodule : sfew_core_tb_top

// File: test/sfew_spi_host.sv
// SPI host model driving chip select, serial clock and data in mode 0
`timescale 1ns/10ps
module sfew_spi_host (
	input wire logic clk_i,
	output logic spi_cs_b_o,
	output logic spi_sck_o,
	output logic spi_mosi_o
);
	initial begin
		spi_cs_b_o = 1'b1;
		spi_sck_o = 1'b0;
		spi_mosi_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	// Bits go MSB first; only refusal scenarios pass a count off a byte boundary
	task automatic xfer(input logic [39:0] b, input int n);
		spi_cs_b_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			spi_mosi_o = b[39-i];
			tick(8);
			spi_sck_o = 1'b1;
			tick(8);
			spi_sck_o = 1'b0;
		end
		tick(8);
		spi_cs_b_o = 1'b1;
		// Released line must not keep showing the last bit
		spi_mosi_o = ~spi_mosi_o;
		tick(20);
	endtask : xfer
endmodule : sfew_spi_host
